/* File: hw/spi_pkg.sv */
// Purpose: shared constants and types of the serial port control block
// Assumes: registers sit on one aligned 32-bit word each, byte address is index times four
// Notes: printed offsets are register indices
package spi_pkg;
  localparam int ADDR_W = 12;
  localparam logic [7:0] CTRL_IDX = 8'hC3;
  localparam logic [7:0] STAT_IDX = 8'hC4;
  localparam logic [7:0] DATA_IDX = 8'hC5;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {2'b00, CTRL_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] STAT_ADDR = {2'b00, STAT_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] DATA_ADDR = {2'b00, DATA_IDX, 2'b00};
  localparam logic [7:0] CTRL_RESET = 8'h14;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam int STAT_DONE_BIT = 7;
  localparam int STAT_COLL_BIT = 6;
  localparam int STAT_EARLY_BIT = 5;
  localparam int STAT_FAULT_BIT = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] LAST_EDGE = 4'hF;
  localparam logic [2:0] RATE_SLOWEST = 3'h6;

  // bit order matches the control byte, msb first
  typedef struct packed {
    logic rateSelHi;
    logic portEnable;
    logic selectPinIgnore;
    logic controllerRole;
    logic clockIdleLevel;
    logic clockSamplePhase;
    logic rateSelMid;
    logic rateSelLo;
  } ctrl_t;

  typedef struct packed {
    logic transferDone;
    logic writeCollision;
    logic selectEarlyRelease;
    logic modeFault;
  } flags_t;

  typedef enum logic {ShIdle = 1'b0, ShRun = 1'b1} shift_state_t;
endpackage

/* File: hw/spi_rate_gen.sv */
// Purpose: half-period tick for the serial clock in controller role
// Assumes: run is low outside a byte
// Notes: code 7 is invalid and runs at the slowest rate
`timescale 1ns/1ps
`default_nettype none
module spi_rate_gen #(
  parameter int CNT_W = 7
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic [2:0] rateCode,
  output logic tick
);
  if (CNT_W < 6) begin
    $error("rate counter too narrow");
  end

  logic [CNT_W-1:0] cnt_q, cnt_d, limit;
  logic tick_q, tick_d;
  logic [2:0] code;

  always_comb begin
    code = (rateCode > spi_pkg::RATE_SLOWEST) ? spi_pkg::RATE_SLOWEST : rateCode;
    // half period is 2^code cycles, full period 2^(code+1)
    limit = CNT_W'((1 << code) - 1);
    tick_d = run && (cnt_q == limit);
    cnt_d = (!run || cnt_q == limit) ? '0 : CNT_W'(cnt_q + 1'b1);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule
`default_nettype wire

/* File: hw/spi_byte_shifter.sv */
// Purpose: eight-bit exchange engine for both roles
// Assumes: serIn and sckSync are already synchronised
// Notes: sixteen clock edges make one byte
`timescale 1ns/1ps
`default_nettype none
module spi_byte_shifter (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic enable,
  input wire logic controller,
  input wire logic clock_idle_level,
  input wire logic clock_sample_phase,
  input wire logic start,
  input wire logic load,
  input wire logic [7:0] txByte,
  input wire logic tick,
  input wire logic sckSync,
  input wire logic serIn,
  input wire logic selActive,
  output logic sckOut,
  output logic outBit,
  output logic busy,
  output logic done,
  output logic early,
  output logic [7:0] rxByte
);
  spi_pkg::shift_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sr_q, sr_d, rx_q, rx_d;
  logic sck_q, sck_d, out_q, out_d, prev_q, prev_d, done_q, done_d, early_q, early_d;
  logic edgeEv, sampleEdge;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sr_d = sr_q;
    rx_d = rx_q;
    sck_d = sck_q;
    out_d = out_q;
    prev_d = sckSync;
    done_d = 1'b0;
    early_d = 1'b0;
    edgeEv = controller ? (state_q == spi_pkg::ShRun && tick) : ((sckSync != prev_q) && selActive);
    // even edge leaves idle; phase picks which edge samples
    sampleEdge = ~(cnt_q[0] ^ clock_sample_phase);
    if (!enable) begin
      state_d = spi_pkg::ShIdle;
      cnt_d = '0;
      sck_d = clock_idle_level;
    end else begin
      if (state_q == spi_pkg::ShIdle && cnt_q == '0) begin
        sck_d = clock_idle_level;
        if (load) begin
          sr_d = txByte;
          out_d = txByte[7];
        end
        if (start && controller) state_d = spi_pkg::ShRun;
      end
      if (edgeEv) begin
        if (controller) sck_d = ~sck_q;
        if (sampleEdge) sr_d = {sr_q[6:0], serIn};
        else out_d = sr_q[7];
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == spi_pkg::LAST_EDGE) begin
          done_d = 1'b1;
          state_d = spi_pkg::ShIdle;
          rx_d = sampleEdge ? {sr_q[6:0], serIn} : sr_q;
        end
      end
      // select released mid-byte: drop the byte
      if (!controller && !selActive && cnt_q != '0) begin
        cnt_d = '0;
        early_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= spi_pkg::ShIdle;
      cnt_q <= '0;
      sr_q <= spi_pkg::DATA_RESET;
      rx_q <= spi_pkg::DATA_RESET;
      sck_q <= 1'b0;
      out_q <= 1'b0;
      prev_q <= 1'b0;
      done_q <= 1'b0;
      early_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sr_q <= sr_d;
      rx_q <= rx_d;
      sck_q <= sck_d;
      out_q <= out_d;
      prev_q <= prev_d;
      done_q <= done_d;
      early_q <= early_d;
    end
  end

  assign sckOut = sck_q;
  assign outBit = out_q;
  assign busy = (state_q == spi_pkg::ShRun) || (cnt_q != '0);
  assign done = done_q;
  assign early = early_q;
  assign rxByte = rx_q;
endmodule
`default_nettype wire

/* File: hw/spi_control_and_interrupts.sv */
// Purpose: control, status and request logic of a byte-wide serial port on AXI4-Lite
// Assumes: ref_clk at 200 MHz, pins are asynchronous to it
// Notes: two interrupt request levels toward the cpu
// Notes on behaviour
// - done flag sets when a byte finishes
// - done flag drives transmitter request
// - select level against role sets fault
// - fault raises error request unless ignoring select
// - ignoring select suppresses fault request
// - bit 6 enables the port
// - bit 5 ignores select pin in controller role and in target role with phase 1
// - target with phase 0 always uses select
// - bit 4 picks controller or target
// - bit 3 sets clock idle level
// - bit 2 picks sampling edge
// - rate bits divide clock by 2 to 128
// - control resets to 0x14
// - status shows done, collision, fault
// - controller fault clears enable and role
// - status read then control write clears fault
// - data write while busy sets collision only
// - early select release flag, cleared by disable
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module spi_control_and_interrupts (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [spi_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [spi_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe,
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe,
  input wire logic selectIn_n,
  output logic txIrq,
  output logic rxErrIrq
);
  spi_pkg::ctrl_t ctrl_q, ctrl_d;
  spi_pkg::flags_t flags_q, flags_d;
  logic doneArm_q, doneArm_d, collArm_q, collArm_d, faultArm_q, faultArm_d;
  logic awHave_q, awHave_d, wHave_q, wHave_d;
  logic [spi_pkg::ADDR_W-1:0] awAddr_q, awAddr_d;
  logic [7:0] wByte_q, wByte_d;
  logic wLane_q, wLane_d;
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d, arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic sckOe_q, sckOe_d, mosiOe_q, mosiOe_d, misoOe_q, misoOe_d, txIrq_q, txIrq_d, rxErrIrq_q, rxErrIrq_d;
  // pin synchronisers: sck, mosi, miso, select
  logic [3:0] sync1_q, sync2_q;
  logic sckSync, mosiSync, misoSync, selSync_n;
  logic doWrite, doRead, wrCtrl, wrData, rdStat, rdData, dataAccess;
  logic ignoreEff, selActive, faultSet, loadByte, startByte;
  logic shSck, shOut, shBusy, shDone, shEarly, rateTick;
  logic [7:0] shRx;

  function automatic logic mapped(input logic [spi_pkg::ADDR_W-1:0] a);
    mapped = (a == spi_pkg::CTRL_ADDR) || (a == spi_pkg::STAT_ADDR) || (a == spi_pkg::DATA_ADDR);
  endfunction

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      // both stages start at idle pin levels, so no false edge or select follows reset
      sync1_q <= 4'h1;
      sync2_q <= 4'h1;
    end else begin
      sync1_q <= {sckIn, mosiIn, misoIn, selectIn_n};
      sync2_q <= sync1_q;
    end
  end

  assign {sckSync, mosiSync, misoSync, selSync_n} = sync2_q;

  // select use: ignore bit counts except target with phase 0
  always_comb begin
    ignoreEff = ctrl_q.selectPinIgnore && (ctrl_q.controllerRole || ctrl_q.clockSamplePhase);
    selActive = ctrl_q.controllerRole || ignoreEff || !selSync_n;
    // controller sees select pulled low by someone else
    faultSet = ctrl_q.portEnable && ctrl_q.controllerRole && !ignoreEff && !selSync_n;
  end

  // bus side: address and data may arrive in either order
  always_comb begin
    awHave_d = awHave_q;
    wHave_d = wHave_q;
    awAddr_d = awAddr_q;
    wByte_d = wByte_q;
    wLane_d = wLane_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (awvalid && awready_q) begin
      awHave_d = 1'b1;
      awAddr_d = awaddr;
    end
    if (wvalid && wready_q) begin
      wHave_d = 1'b1;
      wByte_d = wdata[7:0];
      wLane_d = wstrb[0];
    end
    doWrite = awHave_q && wHave_q && !bvalid_q;
    if (doWrite) begin
      awHave_d = 1'b0;
      wHave_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = mapped(awAddr_q) ? spi_pkg::RESP_OKAY : spi_pkg::RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    doRead = arvalid && arready_q;
    if (doRead) begin
      rvalid_d = 1'b1;
      rresp_d = mapped(araddr) ? spi_pkg::RESP_OKAY : spi_pkg::RESP_SLVERR;
      unique case (araddr)
        spi_pkg::CTRL_ADDR: rdata_d = {24'h00_0000, ctrl_q};
        spi_pkg::STAT_ADDR: rdata_d = {24'h00_0000, flags_q, 4'h0};
        spi_pkg::DATA_ADDR: rdata_d = {24'h00_0000, shRx};
        default: rdata_d = 32'h0000_0000;
      endcase
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    awready_d = !awHave_d;
    wready_d = !wHave_d;
    arready_d = !rvalid_d;
    wrCtrl = doWrite && wLane_q && (awAddr_q == spi_pkg::CTRL_ADDR);
    wrData = doWrite && wLane_q && (awAddr_q == spi_pkg::DATA_ADDR);
    rdStat = doRead && (araddr == spi_pkg::STAT_ADDR);
    rdData = doRead && (araddr == spi_pkg::DATA_ADDR);
  end

  // registers, flags and clearing sequences; a hardware set wins over a clear
  always_comb begin
    ctrl_d = ctrl_q;
    flags_d = flags_q;
    doneArm_d = doneArm_q;
    collArm_d = collArm_q;
    faultArm_d = faultArm_q;
    dataAccess = rdData || wrData;
    loadByte = wrData && !shBusy;
    startByte = loadByte && ctrl_q.portEnable && ctrl_q.controllerRole;
    if (rdStat) begin
      doneArm_d = flags_q.transferDone;
      collArm_d = flags_q.writeCollision;
      faultArm_d = flags_q.modeFault;
    end
    if (dataAccess && doneArm_q) begin
      flags_d.transferDone = 1'b0;
      doneArm_d = 1'b0;
    end
    if (dataAccess && collArm_q) begin
      flags_d.writeCollision = 1'b0;
      collArm_d = 1'b0;
    end
    if (wrCtrl) begin
      ctrl_d = spi_pkg::ctrl_t'(wByte_q);
      if (faultArm_q) begin
        flags_d.modeFault = 1'b0;
        faultArm_d = 1'b0;
      end
    end
    if (!ctrl_q.portEnable) flags_d.selectEarlyRelease = 1'b0;
    if (shDone) flags_d.transferDone = 1'b1;
    // collision leaves the running byte alone
    if (wrData && shBusy) flags_d.writeCollision = 1'b1;
    if (shEarly) flags_d.selectEarlyRelease = 1'b1;
    if (faultSet) begin
      flags_d.modeFault = 1'b1;
      ctrl_d.portEnable = 1'b0;
      ctrl_d.controllerRole = 1'b0;
    end
  end

  // pin enables and cpu requests
  always_comb begin
    sckOe_d = ctrl_q.portEnable && ctrl_q.controllerRole;
    mosiOe_d = ctrl_q.portEnable && ctrl_q.controllerRole;
    misoOe_d = ctrl_q.portEnable && !ctrl_q.controllerRole && (ignoreEff || !selSync_n);
    txIrq_d = flags_q.transferDone;
    rxErrIrq_d = flags_q.modeFault && !ctrl_q.selectPinIgnore;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= spi_pkg::ctrl_t'(spi_pkg::CTRL_RESET);
      flags_q <= '0;
      doneArm_q <= 1'b0;
      collArm_q <= 1'b0;
      faultArm_q <= 1'b0;
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= '0;
      wByte_q <= '0;
      wLane_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= spi_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= spi_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      sckOe_q <= 1'b0;
      mosiOe_q <= 1'b0;
      misoOe_q <= 1'b0;
      txIrq_q <= 1'b0;
      rxErrIrq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      flags_q <= flags_d;
      doneArm_q <= doneArm_d;
      collArm_q <= collArm_d;
      faultArm_q <= faultArm_d;
      awHave_q <= awHave_d;
      wHave_q <= wHave_d;
      awAddr_q <= awAddr_d;
      wByte_q <= wByte_d;
      wLane_q <= wLane_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      sckOe_q <= sckOe_d;
      mosiOe_q <= mosiOe_d;
      misoOe_q <= misoOe_d;
      txIrq_q <= txIrq_d;
      rxErrIrq_q <= rxErrIrq_d;
    end
  end

  spi_rate_gen #(
    .CNT_W(7)
  ) u_rate (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .run(shBusy && ctrl_q.controllerRole),
    .rateCode({ctrl_q.rateSelHi, ctrl_q.rateSelMid, ctrl_q.rateSelLo}),
    .tick(rateTick)
  );

  spi_byte_shifter u_shift (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .enable(ctrl_q.portEnable),
    .controller(ctrl_q.controllerRole),
    .clock_idle_level(ctrl_q.clockIdleLevel),
    .clock_sample_phase(ctrl_q.clockSamplePhase),
    .start(startByte),
    .load(loadByte),
    .txByte(wByte_q),
    .tick(rateTick),
    .sckSync(sckSync),
    .serIn(ctrl_q.controllerRole ? misoSync : mosiSync),
    .selActive(selActive),
    .sckOut(shSck),
    .outBit(shOut),
    .busy(shBusy),
    .done(shDone),
    .early(shEarly),
    .rxByte(shRx)
  );

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign sckOut = shSck;
  assign sckOe = sckOe_q;
  assign mosiOut = shOut;
  assign mosiOe = mosiOe_q;
  assign misoOut = shOut;
  assign misoOe = misoOe_q;
  assign txIrq = txIrq_q;
  assign rxErrIrq = rxErrIrq_q;
endmodule
`default_nettype wire

/* File: sim/spi_ctrl_assertions.sv */
// Purpose: port-level checks of the serial port control block
// Assumes: one clock domain, reset async active low
// Notes: bound to the top module, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module spi_ctrl_assertions (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic sckOe,
  input wire logic mosiOe,
  input wire logic misoOe,
  input wire logic txIrq,
  input wire logic rxErrIrq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered next cycle");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write not answered");
  a_rdata_byte: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_read_refused: assert property (rvalid |-> !arready)
    else $error("address taken while answer pending");
  a_ctrl_drives: assert property (sckOe |-> mosiOe && !misoOe)
    else $error("pin drive does not match role");
  a_fault_stops: assert property ($rose(rxErrIrq) |-> ##[0:2] !sckOe)
    else $error("fault left controller running");
  c_write: cover property (awvalid && awready && wvalid && wready);
  c_done: cover property ($rose(txIrq));
  c_fault: cover property ($rose(rxErrIrq));
  c_target: cover property (misoOe);
endmodule
bind spi_control_and_interrupts spi_ctrl_assertions chk (.ref_clk, .arst_n, .awvalid, .awready, .wvalid,
  .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .sckOe, .mosiOe,
  .misoOe, .txIrq, .rxErrIrq);
`default_nettype wire

/* File: sim/spi_far_end.sv */
// Purpose: behavioural target device across the serial link
// Assumes: clock line follows the controller only while driven
// Notes: released data line shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module spi_far_end (
  input wire logic sck,
  input wire logic sckEn,
  input wire logic mosi,
  input wire logic clock_idle_level,
  input wire logic clock_sample_phase,
  input wire logic load,
  input wire logic fault,
  input wire logic [7:0] txByte,
  output logic miso,
  output logic selectPin_n,
  output logic [7:0] rxByte
);
  logic [7:0] sh;
  logic o;
  assign selectPin_n = !fault;
  assign miso = sckEn ? o : !o;
  // one process owns the shift state, so load and clock never race
  always @(posedge load or sck) begin
    if (load) begin
      sh = txByte;
      o = txByte[7];
    end else if (sckEn) begin
      // leading edge means leaving idle level
      if ((sck !== clock_idle_level) ^ clock_sample_phase) rxByte = {rxByte[6:0], mosi};
      else if (clock_sample_phase) begin
        o = sh[7];
        sh = sh << 1;
      end else begin
        sh = sh << 1;
        o = sh[7];
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/spi_control_and_interrupts_tb.sv */
// Purpose: self-checking bench of the serial port control block
// Assumes: far end is a target device, bus master is this bench
// Notes: low rate codes skip data compare, sync lag eats the half period
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module spi_control_and_interrupts_tb;
  logic ref_clk, arst_n = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe;
  logic txIrq, rxErrIrq, farMiso, selW_n, lastSck = 1'b0, junk = 1'b0;
  logic [1:0] bresp, rresp, rs;
  logic cpolTb = 1'b0, cphaTb = 1'b0, farLoad = 1'b0, farFault = 1'b0;
  logic [7:0] rd, sent, farTx = 8'h00, farRx, ctrlExp;
  logic [2:0] c;
  int err_total = 0, num_checks = 0, edges = 0, cyc = 0, base;
  int edgeAt[int];
  // pins resolved from drive enables; undriven clock follows the bench
  wire logic sckW = sckOe ? sckOut : cpolTb;
  wire logic mosiW = mosiOe ? mosiOut : junk;
  wire logic misoW = misoOe ? misoOut : farMiso;
  spi_control_and_interrupts dut (.ref_clk, .arst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .sckIn(sckW), .sckOut, .sckOe, .mosiIn(mosiW), .mosiOut, .mosiOe, .misoIn(misoW), .misoOut, .misoOe,
    .selectIn_n(selW_n), .txIrq, .rxErrIrq);
  spi_far_end far (.sck(sckW), .sckEn(sckOe), .mosi(mosiW), .clock_idle_level(cpolTb), .clock_sample_phase(cphaTb), .load(farLoad),
    .fault(farFault), .txByte(farTx), .miso(farMiso), .selectPin_n(selW_n), .rxByte(farRx));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    junk <= ~junk;
    cyc++;
    if (sckOut !== lastSck) begin
      edges++;
      edgeAt[edges] = cyc;
    end
    lastSck <= sckOut;
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic hang;
    err_total++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end_sim;
  endtask
  task automatic wrReg(input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'h1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rs = bresp;
    bready <= 1'b0;
    if (n == 100) hang;
  endtask
  task automatic rdReg(input logic [11:0] a);
    int n;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata[7:0];
    rs = rresp;
    rready <= 1'b0;
    if (n == 100) hang;
  endtask
  task automatic waitTx;
    int n;
    for (n = 0; n < 3000 && txIrq !== 1'b1; n++) @(posedge ref_clk);
    if (n == 3000) hang;
  endtask
  initial begin
    void'($urandom(32'hf326_16d0));
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rdReg(spi_pkg::CTRL_ADDR);
    `CHK(rd, spi_pkg::CTRL_RESET)
    rdReg(spi_pkg::STAT_ADDR);
    `CHK(rd, 8'h00)
    `CHK({sckOe, txIrq, rxErrIrq}, 3'h0)
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      cpolTb <= c[0];
      cphaTb <= c[1];
      ctrlExp = {c[2], 3'h7, c[0], c[1], c[1:0]};
      wrReg(spi_pkg::CTRL_ADDR, ctrlExp);
      rdReg(spi_pkg::CTRL_ADDR);
      `CHK(rd, ctrlExp)
      `CHK({sckOe, sckOut}, {1'b1, c[0]})
      sent = 8'($urandom);
      farTx <= 8'($urandom);
      farLoad <= 1'b1;
      @(posedge ref_clk);
      farLoad <= 1'b0;
      base = edges;
      wrReg(spi_pkg::DATA_ADDR, sent);
      `CHK(txIrq, 1'b0)
      if (c == 3'd3) wrReg(spi_pkg::DATA_ADDR, ~sent);
      waitTx;
      `CHK(txIrq, 1'b1)
      `CHK(edges - base, 16)
      `CHK(edgeAt[base + 3] - edgeAt[base + 2], 1 << ((c == 3'd7) ? 6 : c))
      rdReg(spi_pkg::STAT_ADDR);
      `CHK(rd, (c == 3'd3) ? 8'hC0 : 8'h80)
      `CHK(rxErrIrq, 1'b0)
      rdReg(spi_pkg::DATA_ADDR);
      if (c > 3'd1) begin
        `CHK(rd, farTx)
        `CHK(farRx, sent)
      end
      rdReg(spi_pkg::STAT_ADDR);
      `CHK({rd, txIrq}, 9'h000)
    end
    cpolTb <= 1'b0;
    wrReg(spi_pkg::CTRL_ADDR, 8'h70);
    farFault <= 1'b1;
    repeat (10) @(posedge ref_clk);
    `CHK(rxErrIrq, 1'b0)
    rdReg(spi_pkg::CTRL_ADDR);
    `CHK(rd, 8'h70)
    wrReg(spi_pkg::CTRL_ADDR, 8'h50);
    repeat (10) @(posedge ref_clk);
    `CHK({rxErrIrq, sckOe}, 2'h2)
    rdReg(spi_pkg::CTRL_ADDR);
    `CHK(rd, 8'h00)
    farFault <= 1'b0;
    wrReg(spi_pkg::CTRL_ADDR, 8'h20);
    repeat (2) @(posedge ref_clk);
    `CHK(rxErrIrq, 1'b0)
    rdReg(spi_pkg::STAT_ADDR);
    `CHK(rd, 8'h10)
    wrReg(spi_pkg::CTRL_ADDR, 8'h14);
    rdReg(spi_pkg::STAT_ADDR);
    `CHK({rd, rxErrIrq}, 9'h000)
    wrReg(12'h300, 8'hFF);
    `CHK(rs, spi_pkg::RESP_SLVERR)
    rdReg(12'h300);
    `CHK(rs, spi_pkg::RESP_SLVERR)
    rdReg(spi_pkg::CTRL_ADDR);
    `CHK(rd, 8'h14)
    // target role: bench drives the clock pin, the fault line doubles as select
    farFault <= 1'b1;
    wrReg(spi_pkg::CTRL_ADDR, 8'h40);
    sent = 8'($urandom);
    wrReg(spi_pkg::DATA_ADDR, sent);
    repeat (2) @(posedge ref_clk);
    `CHK({misoOe, misoOut}, {1'b1, sent[7]})
    cpolTb <= 1'b1;
    repeat (4) @(posedge ref_clk);
    cpolTb <= 1'b0;
    repeat (4) @(posedge ref_clk);
    `CHK(misoOut, sent[6])
    farFault <= 1'b0;
    wrReg(spi_pkg::CTRL_ADDR, 8'h60);
    rdReg(spi_pkg::STAT_ADDR);
    `CHK({rd, misoOe}, 9'h040)
    wrReg(spi_pkg::CTRL_ADDR, 8'h64);
    rdReg(spi_pkg::STAT_ADDR);
    `CHK({rd, misoOe}, 9'h041)
    wrReg(spi_pkg::CTRL_ADDR, 8'h24);
    rdReg(spi_pkg::STAT_ADDR);
    `CHK({rd, misoOe}, 9'h000)
    end_sim;
  end
endmodule
`default_nettype wire
